// >>> logic/jle_cond.sv
/*
 * condition-code evaluator for the conditional jumps.
 * assumes: indicators are those left by the previous instruction.
 */
`include "jle_defines.svh"

module jle_cond
(
	// condition and indicators
	input  wire logic [2:0] condField,
	input  wire logic [4:0] indicators,
	// result
	output logic            condMet
);

	logic carry;
	logic ovf;
	logic even;
	logic neg;
	logic zero;

	// ==========================================================
	// indicator fields
	assign carry = indicators[`JLE_IND_CARRY];
	assign ovf   = indicators[`JLE_IND_OVF];
	assign even  = indicators[`JLE_IND_EVEN];
	assign neg   = indicators[`JLE_IND_NEG];
	assign zero  = indicators[`JLE_IND_ZERO];

	// condition table
	always_comb
	begin
		case (condField)
			3'h0:    condMet = zero;
			3'h1:    condMet = !zero && !neg;
			3'h2:    condMet = neg;
			3'h3:    condMet = even;
			3'h4:    condMet = neg ^ ovf;
			3'h5:    condMet = (neg ^ ovf) || zero;
			3'h6:    condMet = carry || zero;
			default: condMet = carry;
		endcase
	end

endmodule

// >>> logic/jle_defines.svh
/*
 * constants of the jump and level-exit unit: register offsets, field
 * positions and reset values.
 * assumes: included by bare name from every design file that needs it.
 */
`ifndef JLE_DEFINES_SVH
`define JLE_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define JLE_OFF_CTRL    8'h00
`define JLE_OFF_STATUS  8'h04
`define JLE_OFF_PENDING 8'h08
`define JLE_PTR_PAGE    4'h1
`define JLE_LSW_PAGE    4'h2

// ==========================================================
// field positions
`define JLE_LSW_INPROC  9
`define JLE_LSW_SUMMARY 11
`define JLE_IND_CARRY   4
`define JLE_IND_OVF     3
`define JLE_IND_EVEN    2
`define JLE_IND_NEG     1
`define JLE_IND_ZERO    0

// ==========================================================
// reset values
`define JLE_SUPER_RESET 1'h1
`define JLE_LSW_RESET   16'h0000
`define JLE_PTR_RESET   16'h0000

`endif

// >>> logic/jle_pkg.sv
/*
 * types of the jump and level-exit unit.
 * assumes: compiled before every module that imports it.
 */
package jle_pkg;

	// ==========================================================
	// instruction kinds handed to the unit
	typedef enum logic [2:0]
	{
		JLE_OP_NONE,
		JLE_OP_JUMP,
		JLE_OP_CALL_RELATIVE,
		JLE_OP_BRANCH_IF_COND,
		JLE_OP_BRANCH_IF_NOT_COND,
		JLE_OP_LOOP_COUNT_BRANCH,
		JLE_OP_LEVEL_RETURN
	} jle_op_t;

	// program check reported with a finished instruction
	typedef enum logic [1:0]
	{
		JLE_CHK_NONE,
		JLE_CHK_INVALID_ADDR,
		JLE_CHK_SPEC,
		JLE_CHK_PRIV
	} jle_check_t;

	// execution state
	typedef enum logic
	{
		JLE_RUN,
		JLE_WAIT
	} jle_state_t;

endpackage

// >>> logic/jle_sync.sv
/*
 * two-flop synchroniser for a vector of independent levels.
 * assumes: inputs come from outside the core_clk domain.
 */
module jle_sync
#(
	parameter int W = 4
)
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] stage1;

	// ==========================================================
	// first flop feeds only the second
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= '0;
			dout   <= '0;
		end
		else if (ce)
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// >>> logic/jle_unit.sv
/*
 * execution unit for the relative jump family and level return,
 * with level status words, saved pointers and masks behind an apb slave.
 * assumes: one instruction offered at a time with updated pointer,
 * selected register value, indicators and address validity; interrupt
 * requests are asynchronous levels.
 */
// The implementer's own choices: the address map and register access over APB.
// Notes on behaviour
// - jump offset is sign-extended word displacement doubled, added to updated pointer
// - jumps and level return leave all five indicators unchanged
// - jump checks invalid address, and odd target as specification check
// - call_relative links updated pointer into register, then branches
// - call_relative on invalid address writes link but does not branch
// - three-bit condition field selects one of eight indicator tests
// - conditional jump branches when condition holds, else falls through
// - inverse jump branches when condition false; invalid address is checked
// - loop count decrements nonzero register, branches while result nonzero
// - loop count on invalid address still decrements, never branches
// - level return first clears in-process bit of current level
// - level return weighs pending levels, requests, summary and level masks
// - highest pending or enabled requesting level resumes at its saved pointer
// - summary mask off ignores requests; resume pending or wait
// - nothing pending nor requested puts processor into wait
// - one instruction runs on resumed level before trace sampling; after wake from wait, trace sampling starts at once
`include "jle_defines.svh"

module jle_unit
	import jle_pkg::*;
#(
	parameter int NLEV = 4,
	parameter int LW   = 2
)
(
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst,
	input  wire logic            ce,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// instruction issue
	input  wire logic            issueValid,
	output logic                 issueReady,
	input  wire jle_op_t         opKind,
	input  wire logic [2:0]      condField,
	input  wire logic [7:0]      wordDisp,
	input  wire logic [15:0]     regValue,
	input  wire logic [15:0]     instrPointer,
	input  wire logic [4:0]      indicators,
	input  wire logic            addrValid,
	// results
	output logic                 doneValid,
	output logic [15:0]          nextPtr,
	output logic                 branchTaken,
	output logic                 regWriteEn,
	output logic [15:0]          regWriteData,
	output logic [4:0]           indicatorsOut,
	output logic                 checkValid,
	output jle_check_t           checkCode,
	// levels
	input  wire logic [NLEV-1:0] intReq,
	output logic [LW-1:0]        currentLevel,
	output logic                 waitState,
	output logic                 traceSampleEn
);

	// ==========================================================
	// state
	jle_state_t          state;
	logic                ctrlSuper;
	logic [NLEV-1:0]     levelMask;
	logic [NLEV-1:0]     pending;
	logic [15:0]         levelStatus [NLEV];
	logic [15:0]         savedPtr [NLEV];
	logic                skipTrace;
	jle_check_t          lastCheck;
	logic [NLEV-1:0]     reqSync;

	jle_sync #(.W(NLEV)) u_req_sync
	(
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.din      (intReq),
		.dout     (reqSync)
	);

	// ==========================================================
	// apb decode
	wire          setupPhase = psel && !penable;
	wire          apbWrite   = psel && penable && pwrite && !pslverr;
	wire          isCtrl     = paddr == `JLE_OFF_CTRL;
	wire          isStatus   = paddr == `JLE_OFF_STATUS;
	wire          isPending  = paddr == `JLE_OFF_PENDING;
	wire          aligned    = paddr[1:0] == 2'h0;
	wire          isPtr      = paddr[7:4] == `JLE_PTR_PAGE && aligned;
	wire          isLsw      = paddr[7:4] == `JLE_LSW_PAGE && aligned;
	wire [LW-1:0] regLevel   = LW'(paddr[3:2]);
	wire          mapped     = isCtrl || isStatus || isPending || isPtr || isLsw;
	wire [31:0]   readWord   =
		isCtrl    ? {24'h0, 4'(levelMask), 3'h0, ctrlSuper} :
		isStatus  ? {22'h0, lastCheck, 3'h0, waitState, 2'h0, 2'(currentLevel)} :
		isPending ? {28'h0, 4'(pending)} :
		isPtr     ? {16'h0, savedPtr[regLevel]} :
		isLsw     ? {16'h0, levelStatus[regLevel]} : 32'h0;

	// zero-wait answer, error on unmapped words
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// read data captured during setup
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0;
		else if (ce && setupPhase)
			prdata <= readWord;
	end

	// ==========================================================
	// jump arithmetic
	logic         condMet;
	wire  [15:0]  offset   = {{7{wordDisp[7]}}, wordDisp, 1'b0};
	wire  [15:0]  target   = instrPointer + offset;
	wire  [15:0]  loopDec  = regValue - 16'h0001;
	wire          loopNz   = regValue != 16'h0000;
	wire          take     = ce && issueValid && issueReady;

	jle_cond u_cond
	(
		.condField  (condField),
		.indicators (indicators),
		.condMet    (condMet)
	);

	// ==========================================================
	// level selection
	wire [15:0]     curLsw    = levelStatus[currentLevel];
	wire            summaryOn = curLsw[`JLE_LSW_SUMMARY];
	wire [NLEV-1:0] reqMasked = reqSync & levelMask & {NLEV{summaryOn}};
	wire [NLEV-1:0] exitCand  = pending | reqMasked;
	logic [LW-1:0]  exitPick;
	logic [LW-1:0]  wakePick;

	// level 0 is highest priority
	always_comb
	begin
		exitPick = '0;
		wakePick = '0;
		for (int i = NLEV - 1; i >= 0; i--)
		begin
			if (exitCand[i])
				exitPick = LW'(i);
			if (reqMasked[i])
				wakePick = LW'(i);
		end
	end

	// ==========================================================
	// per-instruction outcome
	logic       nBranch;
	logic       nRegWr;
	logic [15:0] nRegData;
	jle_check_t nCheck;
	logic       nExit;

	always_comb
	begin
		nBranch  = 1'b0;
		nRegWr   = 1'b0;
		nRegData = 16'h0000;
		nCheck   = JLE_CHK_NONE;
		nExit    = 1'b0;
		case (opKind)
			JLE_OP_JUMP:
			begin
				if (!addrValid)
					nCheck = JLE_CHK_INVALID_ADDR;
				else if (target[0])
					nCheck = JLE_CHK_SPEC;
				else
					nBranch = 1'b1;
			end
			JLE_OP_CALL_RELATIVE:
			begin
				nRegWr   = 1'b1;
				nRegData = instrPointer;
				if (!addrValid)
					nCheck = JLE_CHK_INVALID_ADDR;
				else
					nBranch = 1'b1;
			end
			JLE_OP_BRANCH_IF_COND, JLE_OP_BRANCH_IF_NOT_COND:
			begin
				if (!addrValid)
					nCheck = JLE_CHK_INVALID_ADDR;
				else
					nBranch = condMet ^ (opKind == JLE_OP_BRANCH_IF_NOT_COND);
			end
			JLE_OP_LOOP_COUNT_BRANCH:
			begin
				nRegWr   = loopNz;
				nRegData = loopDec;
				if (!addrValid)
					nCheck = JLE_CHK_INVALID_ADDR;
				else
					nBranch = loopNz && loopDec != 16'h0000;
			end
			JLE_OP_LEVEL_RETURN:
			begin
				if (!ctrlSuper)
					nCheck = JLE_CHK_PRIV;
				else
					nExit = 1'b1;
			end
			default:
			begin
				nBranch = 1'b0;
			end
		endcase
	end

	wire exitResume = take && nExit && exitCand != '0;
	wire exitToWait = take && nExit && exitCand == '0;
	wire wake       = state == JLE_WAIT && ce && reqMasked != '0;

	// ==========================================================
	// handshake and level outputs
	assign issueReady    = state == JLE_RUN;
	assign waitState     = state == JLE_WAIT;
	assign traceSampleEn = state == JLE_RUN && !skipTrace;

	// ==========================================================
	// result registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			doneValid     <= 1'b0;
			nextPtr       <= 16'h0000;
			branchTaken   <= 1'b0;
			regWriteEn    <= 1'b0;
			regWriteData  <= 16'h0000;
			indicatorsOut <= 5'h00;
			checkValid    <= 1'b0;
			checkCode     <= JLE_CHK_NONE;
		end
		else if (ce)
		begin
			doneValid     <= take || wake;
			branchTaken   <= take && (nBranch || exitResume);
			regWriteEn    <= take && nRegWr;
			regWriteData  <= nRegData;
			indicatorsOut <= indicators;
			checkValid    <= take && nCheck != JLE_CHK_NONE;
			checkCode     <= take ? nCheck : JLE_CHK_NONE;
			if (wake)
				nextPtr <= savedPtr[wakePick];
			else if (exitResume)
				nextPtr <= savedPtr[exitPick];
			else
				nextPtr <= nBranch ? target : instrPointer;
		end
	end

	// ==========================================================
	// execution state and level bookkeeping
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state        <= JLE_RUN;
			currentLevel <= '0;
			skipTrace    <= 1'b0;
			lastCheck    <= JLE_CHK_NONE;
		end
		else if (ce)
		begin
			if (take && nCheck != JLE_CHK_NONE)
				lastCheck <= nCheck;
			if (exitResume)
			begin
				currentLevel <= exitPick;
				skipTrace    <= 1'b1;
			end
			else if (take)
				skipTrace <= 1'b0;
			if (exitToWait)
				state <= JLE_WAIT;
			else if (wake)
			begin
				state        <= JLE_RUN;
				currentLevel <= wakePick;
			end
		end
	end

	// software registers; hardware updates win in the same cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrlSuper <= `JLE_SUPER_RESET;
			levelMask <= '0;
			pending   <= '0;
			for (int i = 0; i < NLEV; i++)
			begin
				levelStatus[i] <= `JLE_LSW_RESET;
				savedPtr[i]    <= `JLE_PTR_RESET;
			end
		end
		else if (ce)
		begin
			if (apbWrite && isCtrl)
			begin
				ctrlSuper <= pwdata[0];
				levelMask <= NLEV'(pwdata[7:4]);
			end
			if (apbWrite && isPending)
				pending <= NLEV'(pwdata[3:0]);
			if (apbWrite && isPtr)
				savedPtr[regLevel] <= pwdata[15:0];
			if (apbWrite && isLsw)
				levelStatus[regLevel] <= pwdata[15:0];
			if (take && nExit)
				levelStatus[currentLevel][`JLE_LSW_INPROC] <= 1'b0;
			if (exitResume)
			begin
				pending[exitPick] <= 1'b0;
				levelStatus[exitPick][`JLE_LSW_INPROC] <= 1'b1;
			end
			if (wake)
				levelStatus[wakePick][`JLE_LSW_INPROC] <= 1'b1;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_jump_target;
		take && opKind == JLE_OP_JUMP && addrValid && !target[0]
		|=> doneValid && branchTaken && nextPtr == $past(target);
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

	property p_flags_kept;
		take |=> indicatorsOut == $past(indicators);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("indicators altered");

	property p_jump_invalid;
		take && opKind == JLE_OP_JUMP && !addrValid
		|=> checkValid && checkCode == JLE_CHK_INVALID_ADDR && !branchTaken;
	endproperty
	a_jump_invalid: assert property (p_jump_invalid) else $error("jump invalid address not checked");

	property p_call_link;
		take && opKind == JLE_OP_CALL_RELATIVE
		|=> regWriteEn && regWriteData == $past(instrPointer);
	endproperty
	a_call_link: assert property (p_call_link) else $error("link value not written");

	property p_call_invalid;
		take && opKind == JLE_OP_CALL_RELATIVE && !addrValid
		|=> !branchTaken && nextPtr == $past(instrPointer) && regWriteEn;
	endproperty
	a_call_invalid: assert property (p_call_invalid) else $error("call branched on invalid address");

	property p_not_cond;
		take && opKind == JLE_OP_BRANCH_IF_NOT_COND && addrValid
		|=> branchTaken == !$past(condMet);
	endproperty
	a_not_cond: assert property (p_not_cond) else $error("inverse jump decision wrong");

	property p_loop_zero;
		take && opKind == JLE_OP_LOOP_COUNT_BRANCH && regValue == 16'h0000
		|=> !regWriteEn && !branchTaken;
	endproperty
	a_loop_zero: assert property (p_loop_zero) else $error("zero count decremented or jumped");

	property p_loop_invalid;
		take && opKind == JLE_OP_LOOP_COUNT_BRANCH && !addrValid && loopNz
		|=> regWriteEn && regWriteData == $past(loopDec) && !branchTaken;
	endproperty
	a_loop_invalid: assert property (p_loop_invalid) else $error("loop invalid address mishandled");

	property p_priv;
		take && opKind == JLE_OP_LEVEL_RETURN && !ctrlSuper
		|=> checkCode == JLE_CHK_PRIV && !waitState;
	endproperty
	a_priv: assert property (p_priv) else $error("privilege check missing");

	property p_trace_hold;
		exitResume |=> !traceSampleEn;
	endproperty
	a_trace_hold: assert property (p_trace_hold) else $error("trace sampled too early");

	property p_wait_entry;
		exitToWait |=> waitState && !issueReady;
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");

endmodule

// >>> sim/jump_and_level_exit_unit_tb_top.sv
/*
 * self-checking bench of the jump and level-exit unit: apb registers,
 * random jump-family instructions, level return, wait and wake-up.
 * assumes: package and design files from logic/ compiled first.
 */
module jump_and_level_exit_unit_tb_top
	import jle_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// ========================================
	// stimulus and design outputs
	logic        core_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        issueValid = 0;
	logic        issueReady;
	jle_op_t     opKind = JLE_OP_NONE;
	logic [2:0]  condField = 0;
	logic [7:0]  wordDisp = 0;
	logic [15:0] regValue = 0;
	logic [15:0] instrPointer = 0;
	logic [4:0]  indicators = 0;
	logic        addrValid = 1;
	logic        doneValid;
	logic [15:0] nextPtr;
	logic        branchTaken;
	logic        regWriteEn;
	logic [15:0] regWriteData;
	logic [4:0]  indicatorsOut;
	logic        checkValid;
	jle_check_t  checkCode;
	logic [3:0]  intReq = 0;
	logic [1:0]  currentLevel;
	logic        waitState;
	logic        traceSampleEn;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          seed = 95050;

	jle_unit uut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.issueValid(issueValid), .issueReady(issueReady), .opKind(opKind), .condField(condField),
		.wordDisp(wordDisp), .regValue(regValue), .instrPointer(instrPointer), .indicators(indicators),
		.addrValid(addrValid), .doneValid(doneValid), .nextPtr(nextPtr), .branchTaken(branchTaken),
		.regWriteEn(regWriteEn), .regWriteData(regWriteData), .indicatorsOut(indicatorsOut),
		.checkValid(checkValid), .checkCode(checkCode), .intReq(intReq), .currentLevel(currentLevel),
		.waitState(waitState), .traceSampleEn(traceSampleEn));

	// 200 mhz clock and run limit
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			conclude();
		end
	end

	// ========================================
	// expectation functions and shared tasks
	function automatic logic [15:0] dispOff(input logic [7:0] d);
		return {{7{d[7]}}, d, 1'b0};
	endfunction

	// indicator bits: carry, overflow, even, negative, zero
	function automatic logic condOk(input logic [2:0] cf, input logic [4:0] i);
		case (cf)
			3'h0: return i[0];
			3'h1: return !i[0] && !i[1];
			3'h2: return i[1];
			3'h3: return i[2];
			3'h4: return i[1] ^ i[3];
			3'h5: return (i[1] ^ i[3]) | i[0];
			3'h6: return i[4] | i[0];
			default: return i[4];
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// no local limit: only the run timeout ends this wait
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		check(name, rd, exp);
		check("slverr", 32'(err), 32'h0);
	endtask

	// offer one instruction and stop at the cycle of its answer
	task automatic send(input jle_op_t op, input logic [2:0] cf, input logic [7:0] d, input logic [15:0] rv,
		input logic [15:0] ip, input logic [4:0] ind, input logic av);
		@(posedge core_clk);
		issueValid <= 1'b1;
		opKind <= op;
		condField <= cf;
		wordDisp <= d;
		regValue <= rv;
		instrPointer <= ip;
		indicators <= ind;
		addrValid <= av;
		@(posedge core_clk);
		issueValid <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic issue(input jle_op_t op, input logic [2:0] cf, input logic [7:0] d, input logic [15:0] rv,
		input logic [15:0] ip, input logic [4:0] ind, input logic av);
		logic [15:0] tgt;
		logic        br;
		logic        we;
		jle_check_t  ck;
		tgt = ip + dispOff(d);
		we = (op == JLE_OP_CALL_RELATIVE) || (op == JLE_OP_LOOP_COUNT_BRANCH && rv != 16'h0);
		br = (op == JLE_OP_JUMP) ? av & !tgt[0] : (op == JLE_OP_CALL_RELATIVE) ? av :
			(op == JLE_OP_LOOP_COUNT_BRANCH) ? av & (rv > 16'h1) :
			av & (condOk(cf, ind) ^ (op == JLE_OP_BRANCH_IF_NOT_COND));
		ck = av ? ((op == JLE_OP_JUMP && tgt[0]) ? JLE_CHK_SPEC : JLE_CHK_NONE) : JLE_CHK_INVALID_ADDR;
		send(op, cf, d, rv, ip, ind, av);
		check("doneValid", 32'(doneValid), 32'h1);
		check("branchTaken", 32'(branchTaken), 32'(br));
		if (ck == JLE_CHK_NONE)
			check("nextPtr", 32'(nextPtr), 32'(br ? tgt : ip));
		check("checkValid", 32'(checkValid), 32'(ck != JLE_CHK_NONE));
		if (ck != JLE_CHK_NONE)
			check("checkCode", 32'(checkCode), 32'(ck));
		check("regWriteEn", 32'(regWriteEn), 32'(we));
		if (we)
			check("regWriteData", 32'(regWriteData), 32'(op == JLE_OP_CALL_RELATIVE ? ip : rv - 16'h1));
		check("indicatorsOut", 32'(indicatorsOut), 32'(ind));
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ========================================
	// main sequence
	initial
	begin
		int          n;
		jle_op_t     op;
		logic [15:0] ip;
		logic [31:0] rd;
		logic        err;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rdChk("ctrlReset", 8'h00, 32'h1);
		rdChk("pendReset", 8'h08, 32'h0);
		apb(1'b0, 8'h44, 32'h0, rd, err);
		check("unmappedErr", 32'(err), 32'h1);
		check("unmappedData", rd, 32'h0);
		$display("register test done");

		// boundary displacements, pointer wrap and loop counts
		issue(JLE_OP_JUMP, 3'h0, 8'h80, 16'h0, 16'h0000, 5'h1f, 1'b1);
		issue(JLE_OP_JUMP, 3'h0, 8'h7f, 16'h0, 16'hfffe, 5'h00, 1'b1);
		issue(JLE_OP_JUMP, 3'h0, 8'h01, 16'h0, 16'h0101, 5'h00, 1'b1);
		issue(JLE_OP_CALL_RELATIVE, 3'h0, 8'h10, 16'h0, 16'h0200, 5'h00, 1'b0);
		for (int r = 0; r < 3; r++)
			issue(JLE_OP_LOOP_COUNT_BRANCH, 3'h0, 8'hf0, 16'(r), 16'h0300, 5'h0, 1'b1);
		issue(JLE_OP_LOOP_COUNT_BRANCH, 3'h0, 8'hf0, 16'h5, 16'h0300, 5'h0, 1'b0);
		for (int c = 0; c < 16; c++)
			issue(c < 8 ? JLE_OP_BRANCH_IF_COND : JLE_OP_BRANCH_IF_NOT_COND, 3'(c), 8'h08, 16'h0, 16'h0400,
				5'(c * 7), 1'b1);
		for (int i = 0; i < 300; i++)
		begin
			op = jle_op_t'(3'(1 + {$random(seed)} % 5));
			ip = 16'($random(seed)) & 16'hfffe;
			if (op == JLE_OP_JUMP && i % 4 == 0)
				ip[0] = 1'b1;
			issue(op, 3'($random(seed)), 8'($random(seed)), (i % 3 == 0) ? 16'(i % 3) : 16'($random(seed)),
				ip, 5'($random(seed)), ($random(seed) & 7) != 0);
		end
		$display("jump test done");

		// level return: privilege, priority pick, trace hold
		wr(8'h00, 32'h0);
		send(JLE_OP_LEVEL_RETURN, 3'h0, 8'h0, 16'h0, 16'h0500, 5'h0a, 1'b1);
		check("privValid", 32'(checkValid), 32'h1);
		check("privCode", 32'(checkCode), 32'(JLE_CHK_PRIV));
		wr(8'h00, 32'hf1);
		wr(8'h20, 32'h0a00);
		for (int l = 0; l < 4; l++)
			wr(8'(8'h10 + 4 * l), 32'h1000 + 32'h100 * l);
		wr(8'h08, 32'h6);
		send(JLE_OP_LEVEL_RETURN, 3'h0, 8'h0, 16'h0, 16'h0500, 5'h15, 1'b1);
		check("pickLevel", 32'(currentLevel), 32'h1);
		check("pickPtr", 32'(nextPtr), 32'h1100);
		check("pickInd", 32'(indicatorsOut), 32'h15);
		check("traceHeld", 32'(traceSampleEn), 32'h0);
		rdChk("exitInProc", 8'h20, 32'h0800);
		rdChk("pendLeft", 8'h08, 32'h4);
		check("traceStill", 32'(traceSampleEn), 32'h0);
		issue(JLE_OP_JUMP, 3'h0, 8'h02, 16'h0, 16'h1102, 5'h0, 1'b1);
		check("traceFree", 32'(traceSampleEn), 32'h1);

		// summary off: request ignored, pending level resumed, then wait
		@(posedge core_clk);
		intReq <= 4'h1;
		wr(8'h24, 32'h0200);
		send(JLE_OP_LEVEL_RETURN, 3'h0, 8'h0, 16'h0, 16'h0500, 5'h0, 1'b1);
		check("noReqLevel", 32'(currentLevel), 32'h2);
		check("noReqPtr", 32'(nextPtr), 32'h1200);
		wr(8'h28, 32'h0200);
		send(JLE_OP_LEVEL_RETURN, 3'h0, 8'h0, 16'h0, 16'h0500, 5'h0, 1'b1);
		check("waitState", 32'(waitState), 32'h1);
		check("waitReady", 32'(issueReady), 32'h0);
		@(posedge core_clk);
		issueValid <= 1'b1;
		n = 0;
		repeat (5) @(negedge core_clk) n += int'(doneValid !== 1'b0);
		check("waitFetch", 32'(n), 32'h0);
		@(posedge core_clk);
		issueValid <= 1'b0;
		wr(8'h28, 32'h0800);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (doneValid !== 1'b1 && n < 10);
		check("wakeDone", 32'(doneValid), 32'h1);
		check("wakeState", 32'(waitState), 32'h0);
		check("wakePtr", 32'(nextPtr), 32'h1000);
		check("wakeLevel", 32'(currentLevel), 32'h0);
		@(posedge core_clk);
		intReq <= 4'h0;
		$display("level test done");
		conclude();
	end
endmodule
